/* File: verilog/rmsp_modem.sv */
// Purpose: serial modem port of a half duplex radio module
// Assumes: radio front end takes key, coded bits; gives bits, carrier
// Notes:   AXI4-Lite slave for mode, channel and channel table
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module rmsp_uart_rx
   import rmsp_pkg::*;
#(
   parameter int TICK = CFG_TICK_CYC
) (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       line_i,
   output logic [7:0]      data_o,
   output logic            valid_o
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rmsp_rx_t;
   rmsp_rx_t         st_q;
   logic [CNT_W-1:0] tcnt_q;
   logic [3:0]       scnt_q;
   logic [2:0]       bitn_q;
   logic [7:0]       sh_q;
   logic             tick;

   assign tick = (tcnt_q == CNT_W'(TICK - 1));

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tcnt_q <= '0;
      end else begin
         tcnt_q <= tick ? '0 : tcnt_q + 1'b1;
      end
   end

   // leading edge of start, then centre sampling at 16 ticks a bit
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q    <= RX_IDLE;
         scnt_q  <= '0;
         bitn_q  <= '0;
         sh_q    <= '0;
         data_o  <= '0;
         valid_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         if (tick) begin
            scnt_q <= scnt_q + 1'b1;
            unique case (st_q)
               RX_IDLE: begin
                  scnt_q <= '0;
                  if (!line_i) begin
                     st_q <= RX_START;
                  end
               end
               RX_START: begin
                  if (scnt_q == 4'h7) begin
                     scnt_q <= '0;
                     bitn_q <= '0;
                     st_q   <= line_i ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  if (scnt_q == 4'hF) begin
                     sh_q   <= {line_i, sh_q[7:1]};
                     bitn_q <= bitn_q + 1'b1;
                     if (bitn_q == 3'h7) begin
                        st_q <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (scnt_q == 4'hF) begin
                     st_q    <= RX_IDLE;
                     data_o  <= sh_q;
                     valid_o <= line_i;
                  end
               end
            endcase
         end
      end
   end
endmodule // rmsp_uart_rx

// Operation
// - key transmitter whenever serial data arrives
// - coded radio frames; only valid characters output
// - force pin low gives constant transmit
// - modem input read with true polarity
// - modem output driven inverted
// - carrier gating only while enable pin low
// - modem uses serial channel; select pins carry data
// - modem rate is half configuration rate
// - transmit starts after 50 ms switch-on time
// - receive output held idle 50 ms after reset
// - outside modem mode inverted pins choose channel
// - squelch flag low while carrier, else released
// - user channel table of 128 entries
// - configuration port at 2400 baud, 8N1
// - modem command enables modem on serial channel
// - parallel command disables modem, pins select channel
module rmsp_modem
   import rmsp_pkg::*;
#(
   parameter int CFG_TICK = CFG_TICK_CYC,
   parameter int TX_ON    = TX_ON_CYC,
   parameter int SETTLE   = SETTLE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   output logic [1:0]       s_axi_bresp_o,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   input  wire logic [7:0]  s_axi_araddr_i,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   input  wire logic        force_transmit_n_i,
   input  wire logic        carrier_gate_enable_n_i,
   input  wire logic        config_serial_in_i,
   input  wire logic [2:0]  channel_select_n_i,
   output logic [2:0]       channel_select_n_o,
   output logic [2:0]       channel_select_n_oe_n_o,
   output logic             squelch_flag_o,
   output logic             squelch_flag_oe_n_o,
   output logic             radio_tx_key_o,
   output logic             radio_tx_bit_o,
   input  wire logic        radio_rx_bit_i,
   input  wire logic        radio_carrier_i,
   output logic [N_W-1:0]   synth_n_o
);
   localparam int MDM_TICK = 2 * CFG_TICK;
   localparam int MDM_BIT  = OVS * MDM_TICK;
   localparam logic [CNT_W-1:0] BIT_END = CNT_W'(MDM_BIT - 1);
   localparam logic [CNT_W-1:0] BIT_MID = CNT_W'(MDM_BIT / 2);
   localparam logic [CNT_W-1:0] TX_ON_C = CNT_W'(TX_ON);
   localparam logic [CNT_W-1:0] SET_C   = CNT_W'(SETTLE);

   function automatic logic code_ok(input logic [FRM_W-1:0] f);
      return (f[FRM_W-1 -: 2] == FRM_SYNC) && (f[15:8] == ~f[7:0]);
   endfunction

   function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n,
                                       input logic [3:0] s);
      return (n & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}})
           | (o & ~{{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}});
   endfunction

   logic [PIN_W-1:0] pin_raw, s1_q, s2_q, s3_q, pin_f_q;
   logic             aw_q, w_q, bvalid_q, rvalid_q, wr_now;
   logic [7:0]       awaddr_q;
   logic [31:0]      wdata_q, rd_w, rdata_q;
   logic [31:0]      mode_m, chan_m, tidx_m, tdat_m;
   logic [3:0]       wstrb_q;
   logic [1:0]       bresp_q, rresp_q;
   logic             rd_ok, wr_ok;
   logic             modem_q;
   logic [CH_W-1:0]  ser_ch_q, tidx_q, act_ch;
   logic [N_W-1:0]   tbl [TBL_DEPTH];
   logic             cfg_v, mrx_v, modem_serial_in;
   logic [7:0]       cfg_d, mrx_d, hold_q;
   logic             pend_q, busy_q, key_q, tx_ready;
   logic [CNT_W-1:0] warm_q, btim_q, rtim_q, otim_q, sett_q;
   logic [FRM_W-1:0] sh_q, rsh_q;
   logic [4:0]       bcnt_q;
   logic             rs_q, hit, settled, obusy_q, sq_oe_n_q;
   logic [9:0]       osh_q;
   logic [3:0]       ocnt_q;

   // three-stage pin synchronisers, change taken when stages 2 and 3 agree
   assign pin_raw = {radio_carrier_i, radio_rx_bit_i, config_serial_in_i,
                     carrier_gate_enable_n_i, force_transmit_n_i, channel_select_n_i};

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_q    <= PIN_RST;
         s2_q    <= PIN_RST;
         s3_q    <= PIN_RST;
         pin_f_q <= PIN_RST;
      end else begin
         s1_q    <= pin_raw;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         pin_f_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_f_q & (s2_q ^ s3_q));
      end
   end

   // AXI4-Lite write: address and data taken in either order
   assign s_axi_awready_o = !aw_q && !bvalid_q;
   assign s_axi_wready_o  = !w_q && !bvalid_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign wr_now = aw_q && w_q && !bvalid_q;
   assign wr_ok  = awaddr_q inside {ADDR_MODE, ADDR_CHAN, ADDR_TIDX, ADDR_TDAT, ADDR_STAT};

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OK;
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
         end
         if (wr_now) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? RESP_OK : RESP_ERR;
         end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read
   assign s_axi_arready_o = !rvalid_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;

   always_comb begin
      rd_w  = '0;
      rd_ok = 1'b1;
      unique case (s_axi_araddr_i)
         ADDR_MODE: rd_w[0] = modem_q;
         ADDR_CHAN: rd_w[CH_W-1:0] = ser_ch_q;
         ADDR_TIDX: rd_w[CH_W-1:0] = tidx_q;
         ADDR_TDAT: rd_w[N_W-1:0] = tbl[tidx_q];
         ADDR_STAT: begin
            rd_w[4:0] = {settled, tx_ready, key_q, pin_f_q[P_CAR], modem_q};
            rd_w[ST_ACT_LSB +: CH_W] = act_ch;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OK;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_w;
         rresp_q  <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (rvalid_q && s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // configuration port at 2400 baud
   rmsp_uart_rx #(.TICK(CFG_TICK)) u_cfg_rx (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .line_i    (pin_f_q[P_CFG]),
      .data_o    (cfg_d),
      .valid_o   (cfg_v)
   );

   // byte-merged write words, narrow registers sit in the low bits
   assign mode_m = mrg({31'h0, modem_q}, wdata_q, wstrb_q);
   assign chan_m = mrg({25'h0, ser_ch_q}, wdata_q, wstrb_q);
   assign tidx_m = mrg({25'h0, tidx_q}, wdata_q, wstrb_q);
   assign tdat_m = mrg({16'h0, tbl[tidx_q]}, wdata_q, wstrb_q);

   // mode and serial channel; bus write beats a same-cycle config byte
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         modem_q  <= 1'b0;
         ser_ch_q <= '0;
         tidx_q   <= '0;
      end else if (wr_now) begin
         if (awaddr_q == ADDR_MODE) begin
            modem_q <= mode_m[0];
         end
         if (awaddr_q == ADDR_CHAN) begin
            ser_ch_q <= chan_m[CH_W-1:0];
         end
         if (awaddr_q == ADDR_TIDX) begin
            tidx_q <= tidx_m[CH_W-1:0];
         end
      end else if (cfg_v) begin
         if (cfg_d == CMD_MODEM) begin
            modem_q <= 1'b1;
         end else if (cfg_d == CMD_PAR) begin
            modem_q <= 1'b0;
         end else if (!cfg_d[7]) begin
            ser_ch_q <= cfg_d[CH_W-1:0];
         end
      end
   end

   // channel table and synthesiser word
   always_ff @(posedge clk_i) begin
      if (wr_now && awaddr_q == ADDR_TDAT) begin
         tbl[tidx_q] <= tdat_m[N_W-1:0];
      end
   end

   // invert the three pins before widening, so the upper bits stay zero
   assign act_ch = modem_q ? ser_ch_q : {4'h0, ~pin_f_q[2:0]};

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         synth_n_o <= '0;
      end else begin
         synth_n_o <= tbl[act_ch];
      end
   end

   // modem input on select pin 0, idle high outside modem mode
   assign modem_serial_in = modem_q ? pin_f_q[0] : 1'b1;

   rmsp_uart_rx #(.TICK(MDM_TICK)) u_mdm_rx (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .line_i    (modem_serial_in),
      .data_o    (mrx_d),
      .valid_o   (mrx_v)
   );

   // keying and switch-on delay
   assign tx_ready = (warm_q == TX_ON_C);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         key_q  <= 1'b0;
         warm_q <= '0;
      end else begin
         key_q <= !pin_f_q[P_FORCE] || pend_q || busy_q;
         if (!key_q) begin
            warm_q <= '0;
         end else if (!tx_ready) begin
            warm_q <= warm_q + 1'b1;
         end
      end
   end

   assign radio_tx_key_o = key_q;
   assign radio_tx_bit_o = sh_q[FRM_W-1];

   // one character held; a newer one overwrites it, arrival wins over load
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pend_q <= 1'b0;
         hold_q <= '0;
      end else if (mrx_v) begin
         pend_q <= 1'b1;
         hold_q <= mrx_d;
      end else if (tx_ready && !busy_q) begin
         pend_q <= 1'b0;
      end
   end

   // coded frame: sync, byte, complement
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_q <= 1'b0;
         sh_q   <= '1;
         bcnt_q <= '0;
         btim_q <= '0;
      end else if (!busy_q) begin
         if (tx_ready && pend_q) begin
            busy_q <= 1'b1;
            sh_q   <= {FRM_SYNC, hold_q, ~hold_q};
            bcnt_q <= '0;
            btim_q <= '0;
         end
      end else if (btim_q == BIT_END) begin
         btim_q <= '0;
         sh_q   <= {sh_q[FRM_W-2:0], 1'b1};
         bcnt_q <= bcnt_q + 1'b1;
         busy_q <= (bcnt_q != 5'(FRM_W - 1));
      end else begin
         btim_q <= btim_q + 1'b1;
      end
   end

   // radio receive: sample mid bit, match coded frames only
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rtim_q <= '0;
         rs_q   <= 1'b0;
         rsh_q  <= '1;
      end else begin
         rtim_q <= (rtim_q == BIT_END) ? '0 : rtim_q + 1'b1;
         rs_q   <= (rtim_q == BIT_MID);
         if (hit) begin
            rsh_q <= '1;
         end else if (rs_q) begin
            rsh_q <= {rsh_q[FRM_W-2:0], pin_f_q[P_RXB]};
         end
      end
   end

   assign hit = rs_q && code_ok(rsh_q) && modem_q
                && (pin_f_q[P_GATE] || pin_f_q[P_CAR]);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sett_q <= '0;
      end else if (!settled) begin
         sett_q <= sett_q + 1'b1;
      end
   end

   assign settled = (sett_q == SET_C);

   // modem output character, start low, LSB first
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         obusy_q <= 1'b0;
         osh_q   <= '1;
         ocnt_q  <= '0;
         otim_q  <= '0;
      end else if (!obusy_q) begin
         if (hit && settled) begin
            obusy_q <= 1'b1;
            osh_q   <= {1'b1, rsh_q[15:8], 1'b0};
            ocnt_q  <= '0;
            otim_q  <= '0;
         end
      end else if (otim_q == BIT_END) begin
         otim_q  <= '0;
         osh_q   <= {1'b1, osh_q[9:1]};
         ocnt_q  <= ocnt_q + 1'b1;
         obusy_q <= (ocnt_q != 4'h9);
      end else begin
         otim_q <= otim_q + 1'b1;
      end
   end

   assign channel_select_n_o      = {1'b1, ~osh_q[0], 1'b1};
   assign channel_select_n_oe_n_o = {1'b1, !modem_q, 1'b1};

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sq_oe_n_q <= 1'b1;
      end else begin
         sq_oe_n_q <= !pin_f_q[P_CAR];
      end
   end

   assign squelch_flag_o      = 1'b0;
   assign squelch_flag_oe_n_o = sq_oe_n_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   force_key_a: assert property (!pin_f_q[P_FORCE] |=> radio_tx_key_o)
      else $error("forced transmit not keyed");
   data_key_a: assert property (pend_q |=> radio_tx_key_o)
      else $error("pending data not keyed");
   warm_tx_a: assert property ($rose(busy_q) |-> warm_q == TX_ON_C && key_q)
      else $error("frame sent before switch-on time");
   settle_out_a: assert property (!settled |-> !obusy_q && channel_select_n_o[1] == 1'b0)
      else $error("output active before settling");
   inv_out_a: assert property (modem_q |-> !channel_select_n_oe_n_o[1]
                               && channel_select_n_o[1] != osh_q[0])
      else $error("modem output not inverted");
   gate_cd_a: assert property (!pin_f_q[P_GATE] && !pin_f_q[P_CAR] |=> !$rose(obusy_q))
      else $error("character passed without carrier");
   code_only_a: assert property ($rose(obusy_q) |-> $past(rs_q && code_ok(rsh_q)))
      else $error("uncoded character output");
   par_cmd_a: assert property (cfg_v && cfg_d == CMD_PAR && !wr_now
                               |=> !modem_q && act_ch == {4'h0, ~pin_f_q[2:0]})
      else $error("parallel command ignored");
   mod_cmd_a: assert property (cfg_v && cfg_d == CMD_MODEM && !wr_now
                               |=> modem_q && act_ch == ser_ch_q)
      else $error("modem command ignored");
   squelch_a: assert property (pin_f_q[P_CAR] |=> !squelch_flag_oe_n_o)
      else $error("squelch flag not driven low");
endmodule // rmsp_modem

`default_nettype wire

/* File: common/rmsp_pkg.sv */
// Purpose: shared constants of the radio modem serial port
// Assumes: 250 MHz core clock
// Notes:   cycle counts derive from the times and rates below
package rmsp_pkg;
   localparam int CLK_HZ       = 250_000_000;
   localparam int CFG_BAUD     = 2400;
   localparam int OVS          = 16;
   localparam int TX_ON_MS     = 50;
   localparam int RX_SETTLE_MS = 50;
   localparam int CFG_TICK_CYC = CLK_HZ / (CFG_BAUD * OVS);
   localparam int TX_ON_CYC    = (CLK_HZ / 1000) * TX_ON_MS;
   localparam int SETTLE_CYC   = (CLK_HZ / 1000) * RX_SETTLE_MS;
   localparam int CNT_W        = 24;
   localparam int CH_W         = 7;
   localparam int N_W          = 16;
   localparam int TBL_DEPTH    = 128;
   localparam int FRM_W        = 18;
   localparam int PIN_W        = 8;
   localparam int P_FORCE      = 3;
   localparam int P_GATE       = 4;
   localparam int P_CFG        = 5;
   localparam int P_RXB        = 6;
   localparam int P_CAR        = 7;
   localparam logic [PIN_W-1:0] PIN_RST = 8'h7F;
   localparam logic [1:0] FRM_SYNC  = 2'h2;
   localparam logic [7:0] CMD_MODEM = 8'h80;
   localparam logic [7:0] CMD_PAR   = 8'h81;
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CHAN = 8'h04;
   localparam logic [7:0] ADDR_TIDX = 8'h08;
   localparam logic [7:0] ADDR_TDAT = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam int ST_ACT_LSB = 8;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

/* File: sim/rmsp_host.sv */
// Purpose: host serial port model on the modem pins
// Assumes: bit times given in clock cycles
// Notes:   modem in on pin 0, inverted modem out seen on pin 1
`timescale 1ns/1ps
`default_nettype none
module rmsp_host #(
   parameter int MBIT = 128
) (
   input  wire logic       clk_i,
   input  wire logic       rx_n_i,
   output logic [2:0]      pin_o,
   output logic            cfg_o
);
   initial begin
      pin_o = 3'h7;
      cfg_o = 1'h1;
   end
   task automatic drive(input logic [2:0] v);
      pin_o <= v;
   endtask
   // 8N1 lsb first; sel picks the config line at half the bit time
   task automatic send(input logic sel, input logic [7:0] b);
      logic [9:0] f;
      f = {1'h1, b, 1'h0};
      for (int i = 0; i < 10; i++) begin
         if (sel) cfg_o <= f[i];
         else pin_o[0] <= f[i];
         repeat (sel ? MBIT / 2 : MBIT) @(posedge clk_i);
      end
   endtask
   // waits for an inverted start bit, samples bit centres
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      while (rx_n_i !== 1'h1 && n < 8000) begin
         @(posedge clk_i);
         n++;
      end
      ok = (n < 8000);
      repeat (MBIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (MBIT) @(posedge clk_i);
         b[i] = ~rx_n_i;
      end
      repeat (MBIT) @(posedge clk_i);
   endtask
endmodule // rmsp_host
`default_nettype wire

/* File: sim/radio_modem_serial_port_tb_top.sv */
// Purpose: self-checking bench of the modem serial port
// Assumes: radio bit stream looped back to the receiver
// Notes:   short counts: tick 4, switch-on 50, settle 20
`timescale 1ns/1ps
`default_nettype none
module radio_modem_serial_port_tb_top
   import rmsp_pkg::*;
;
   logic           clk_i = 1'h0;
   logic           sys_rst_i = 1'h1;
   logic           awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic           arvalid = 1'h0, rready = 1'h0;
   logic [7:0]     awaddr = 8'h00, araddr = 8'h00, b, got;
   logic [31:0]    wdata = 32'h0, rdata, d;
   logic [3:0]     wstrb = 4'hF;
   logic           force_n = 1'h1, gate_n = 1'h1, car = 1'h0;
   logic           awready, wready, bvalid, arready, rvalid, ok;
   logic           tx_key, tx_bit, sq, sq_oe_n, cfg;
   logic [1:0]     bresp, rresp, r;
   logic [2:0]     cs_o, cs_oe_n, host_pin, pin;
   logic [N_W-1:0] synth;
   logic [6:0]     ch;
   logic [15:0]    w;
   int             error_cnt = 0;
   int             comparisons = 0;
   always #2 clk_i = ~clk_i;
   assign pin = (~cs_oe_n & cs_o) | (cs_oe_n & host_pin);
   rmsp_modem #(.CFG_TICK(4), .TX_ON(50), .SETTLE(20)) u_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .force_transmit_n_i(force_n), .carrier_gate_enable_n_i(gate_n),
      .config_serial_in_i(cfg), .channel_select_n_i(pin), .channel_select_n_o(cs_o),
      .channel_select_n_oe_n_o(cs_oe_n), .squelch_flag_o(sq),
      .squelch_flag_oe_n_o(sq_oe_n), .radio_tx_key_o(tx_key), .radio_tx_bit_o(tx_bit),
      .radio_rx_bit_i(tx_bit), .radio_carrier_i(car), .synth_n_o(synth)
   );
   rmsp_host #(.MBIT(128)) u_host (
      .clk_i(clk_i), .rx_n_i(pin[1]), .pin_o(host_pin), .cfg_o(cfg)
   );
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   // handshakes sampled at the falling edge, where slave outputs are settled
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_hit, w_hit, b_hit;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge clk_i);
         aw_hit = awvalid && awready;
         w_hit = wvalid && wready;
         b_hit = bvalid;
         rs = bresp;
         @(posedge clk_i);
         if (aw_hit) awvalid <= 1'h0;
         if (w_hit) wvalid <= 1'h0;
      end while (b_hit !== 1'h1);
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ar_hit, r_hit;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge clk_i);
         ar_hit = arvalid && arready;
         r_hit = rvalid;
         v = rdata;
         rs = rresp;
         @(posedge clk_i);
         if (ar_hit) arvalid <= 1'h0;
      end while (r_hit !== 1'h1);
      rready <= 1'h0;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      wrap_up();
   end
   initial begin
      d = $urandom(22043);
      repeat (4) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      rd(ADDR_MODE, d, r);
      chk("mode_reset", 0, d);
      rd(8'h14, d, r);
      chk("unmapped_rd", RESP_ERR, r);
      wr(8'h14, 1, r);
      chk("unmapped_wr", RESP_ERR, r);
      for (int k = 0; k < 8; k++) begin
         u_host.drive(~k[2:0]);
         repeat (5) @(posedge clk_i);
         rd(ADDR_STAT, d, r);
         chk("par_chan", k, d[14:8]);
      end
      u_host.drive(3'h7);
      ch = 7'($urandom);
      w = 16'($urandom);
      wr(ADDR_CHAN, ch, r);
      wr(ADDR_TIDX, ch, r);
      wr(ADDR_TDAT, w, r);
      rd(ADDR_TDAT, d, r);
      chk("tdat", w, d);
      wstrb <= 4'h1;
      wr(ADDR_TDAT, {16'hFFFF, ~w}, r);
      w[7:0] = ~w[7:0];
      wstrb <= 4'hF;
      rd(ADDR_TDAT, d, r);
      chk("tdat_strb", w, d);
      wr(ADDR_MODE, 1, r);
      rd(ADDR_STAT, d, r);
      chk("ser_chan", ch, d[14:8]);
      chk("synth", w, synth);
      chk("pin_oe", 3'h5, cs_oe_n);
      car <= 1'h1;
      repeat (6) @(posedge clk_i);
      chk("sq_on", 0, sq_oe_n);
      chk("sq_level", 0, sq);
      car <= 1'h0;
      repeat (6) @(posedge clk_i);
      chk("sq_off", 1, sq_oe_n);
      // host waits for each reply, or the 8000-cycle timeout when none comes, before the next send
      for (int k = 0; k < 4; k++) begin
         b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         gate_n <= (k < 2);
         car <= (k == 2);
         fork
            u_host.send(1'h0, b);
            u_host.recv(got, ok);
            begin
               repeat (1300) @(posedge clk_i);
               chk("tx_key", 1, tx_key);
            end
         join
         chk("rx_ok", k < 3, ok);
         if (k < 3) chk("rx_byte", b, got);
      end
      gate_n <= 1'h1;
      force_n <= 1'h0;
      repeat (6) @(posedge clk_i);
      chk("force_on", 1, tx_key);
      force_n <= 1'h1;
      repeat (3000) @(posedge clk_i);
      chk("force_off", 0, tx_key);
      u_host.send(1'h1, CMD_PAR);
      repeat (10) @(posedge clk_i);
      rd(ADDR_MODE, d, r);
      chk("cfg_par", 0, d);
      chk("cfg_par_oe", 3'h7, cs_oe_n);
      u_host.send(1'h1, 8'h2A);
      u_host.send(1'h1, CMD_MODEM);
      repeat (10) @(posedge clk_i);
      rd(ADDR_STAT, d, r);
      chk("cfg_modem", 1, d[0]);
      chk("cfg_chan", 8'h2A, d[14:8]);
      wrap_up();
   end
endmodule // radio_modem_serial_port_tb_top
`default_nettype wire
